// ### rtl/gpo_cfg.svh
// Register offsets, field positions and reset values of the port block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GPO_CFG_SVH
`define GPO_CFG_SVH

`define GPO_ADDR_W 6
`define GPO_OFS_PIN_A 6'h00
`define GPO_OFS_DIR_A 6'h01
`define GPO_OFS_OUT_A 6'h02
`define GPO_OFS_PIN_B 6'h03
`define GPO_OFS_DIR_B 6'h04
`define GPO_OFS_OUT_B 6'h05
`define GPO_OFS_PIN_C 6'h06
`define GPO_OFS_DIR_C 6'h07
`define GPO_OFS_OUT_C 6'h08
`define GPO_OFS_CTRL 6'h35

`define GPO_CTRL_SCAN_DIS 7
`define GPO_CTRL_PUD 4
`define GPO_CTRL_VEC_SEL 1
`define GPO_CTRL_VEC_CHG 0
`define GPO_CTRL_RW_MASK 8'h93

`define GPO_RST_BYTE 8'h00
`define GPO_RX_PIN 0
`define GPO_TX_PIN 1
`define GPO_IRQ0_PIN 2
`define GPO_IRQ1_PIN 3
`define GPO_CAPTURE_PIN 6

`endif

// ### rtl/gpo_pkg.sv
// Types shared by the port block and its pin cell.
// Assumes the configuration header sits in the include path.
`default_nettype none
`include "gpo_cfg.svh"

package gpo_pkg;
  typedef logic [7:0] gpo_byte_t;
  typedef logic [`GPO_ADDR_W-1:0] gpo_addr_t;
endpackage : gpo_pkg

`default_nettype wire

// ### rtl/gpo_pin_cell.sv
// A row of pin cells: synchroniser, input gating and override muxes.
// Assumes pin levels are asynchronous inputs and overrides come from peripherals.
`default_nettype none
`include "gpo_cfg.svh"

module gpo_pin_cell #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] dirBit,
  input wire logic [WIDTH-1:0] outBit,
  input wire logic pullupDisable,
  input wire logic sleepGate,
  input wire logic [WIDTH-1:0] pullup_override_en,
  input wire logic [WIDTH-1:0] pullup_override_val,
  input wire logic [WIDTH-1:0] dir_override_en,
  input wire logic [WIDTH-1:0] dir_override_val,
  input wire logic [WIDTH-1:0] outval_override_en,
  input wire logic [WIDTH-1:0] outval_override_val,
  input wire logic [WIDTH-1:0] input_en_override_en,
  input wire logic [WIDTH-1:0] input_en_override_val,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic [WIDTH-1:0] pullupOn,
  output logic [WIDTH-1:0] inLevel
);
  import gpo_pkg::*;

  logic [WIDTH-1:0] syncMeta;
  logic [WIDTH-1:0] syncQ;
  logic [WIDTH-1:0] effDir;
  logic [WIDTH-1:0] inputEn;

  // ----------------------------------------
  // Two-flop synchroniser
  // ----------------------------------------
  // Only the second stage is looked at, so metastability never reaches logic.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      syncMeta <= '0;
      syncQ <= '0;
    end else if (clkEn) begin
      syncMeta <= pinIn;
      syncQ <= syncMeta;
    end
  end

  // ----------------------------------------
  // Override muxes
  // ----------------------------------------
  // Without its override, pull-up only on an input pin with its data bit set, and never under the global disable.
  assign effDir = (dir_override_en & dir_override_val) | (~dir_override_en & dirBit);
  assign pinOe = effDir;
  assign pinOut = (outval_override_en & outval_override_val) | (~outval_override_en & outBit);
  assign pullupOn = (pullup_override_en & pullup_override_val) | (~pullup_override_en & ~dirBit & outBit & {WIDTH{~pullupDisable}});
  assign inputEn = (input_en_override_en & input_en_override_val) | (~input_en_override_en & {WIDTH{~sleepGate}});
  assign inLevel = syncQ & inputEn;

  a_sync_two_flop: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn ##1 clkEn |=> syncQ == $past(pinIn, 2))
    else $error("synchroniser latency is not two enabled edges");

endmodule : gpo_pin_cell

`default_nettype wire

// ### rtl/gpo_port.sv
// Port block: registers for ports A to C, control register and the
// port D alternate-function overrides.
// Assumes one clock, software on a plain strobe port, peripherals on the override side.
//
// Our own choice: the strobed register port.
`default_nettype none
`include "gpo_cfg.svh"

module gpo_port #(
  parameter int SPIKE_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire gpo_pkg::gpo_addr_t regAddr,
  input wire gpo_pkg::gpo_byte_t regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output gpo_pkg::gpo_byte_t regRdData,
  input wire gpo_pkg::gpo_byte_t portAPinIn,
  output gpo_pkg::gpo_byte_t portAPinOut,
  output gpo_pkg::gpo_byte_t portAPinOe,
  output gpo_pkg::gpo_byte_t portAPullup,
  input wire gpo_pkg::gpo_byte_t portBPinIn,
  output gpo_pkg::gpo_byte_t portBPinOut,
  output gpo_pkg::gpo_byte_t portBPinOe,
  output gpo_pkg::gpo_byte_t portBPullup,
  input wire gpo_pkg::gpo_byte_t portCPinIn,
  output gpo_pkg::gpo_byte_t portCPinOut,
  output gpo_pkg::gpo_byte_t portCPinOe,
  output gpo_pkg::gpo_byte_t portCPullup,
  input wire gpo_pkg::gpo_byte_t portDPinIn,
  input wire gpo_pkg::gpo_byte_t portDOutputData,
  input wire gpo_pkg::gpo_byte_t portDDirection,
  output gpo_pkg::gpo_byte_t portDPinOut,
  output gpo_pkg::gpo_byte_t portDPinOe,
  output gpo_pkg::gpo_byte_t portDPullup,
  output logic [1:0] portDSlewCtrl,
  input wire logic sleepInputDisable,
  input wire logic serialTxEnable,
  input wire logic serialRxEnable,
  input wire logic serialTxData,
  output logic serialRxPin,
  input wire logic [3:0] compareOutEnable,
  input wire logic [3:0] compareOutValue,
  output logic timer1CaptureIn,
  input wire logic [1:0] extIrqEnable,
  output logic [1:0] extIrqIn,
  input wire gpo_pkg::gpo_byte_t pinchangeMask,
  input wire logic pinchangeGroup3Enable,
  output gpo_pkg::gpo_byte_t pinchangeIn,
  input wire logic twowireEnable,
  output logic twowireSclIn,
  output logic twowireSdaIn,
  output logic scanPortDisable,
  output logic vectorTableSelect,
  output logic vectorChangeEnable
);
  import gpo_pkg::*;

  gpo_byte_t outA;
  gpo_byte_t outB;
  gpo_byte_t outC;
  gpo_byte_t dirA;
  gpo_byte_t dirB;
  gpo_byte_t dirC;
  gpo_byte_t ctrl;
  gpo_byte_t levA;
  gpo_byte_t levB;
  gpo_byte_t levC;
  gpo_byte_t levD;
  gpo_byte_t next_rdData;
  logic globalPullupDisable;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // A write of ones to an input register toggles the data bits, a cheap bit flip.
  wire logic wrEn = regWrStrobe & clkEn;
  wire logic wrPinA = wrEn & (regAddr == `GPO_OFS_PIN_A);
  wire logic wrDirA = wrEn & (regAddr == `GPO_OFS_DIR_A);
  wire logic wrOutA = wrEn & (regAddr == `GPO_OFS_OUT_A);
  wire logic wrPinB = wrEn & (regAddr == `GPO_OFS_PIN_B);
  wire logic wrDirB = wrEn & (regAddr == `GPO_OFS_DIR_B);
  wire logic wrOutB = wrEn & (regAddr == `GPO_OFS_OUT_B);
  wire logic wrPinC = wrEn & (regAddr == `GPO_OFS_PIN_C);
  wire logic wrDirC = wrEn & (regAddr == `GPO_OFS_DIR_C);
  wire logic wrOutC = wrEn & (regAddr == `GPO_OFS_OUT_C);
  wire logic wrCtrl = wrEn & (regAddr == `GPO_OFS_CTRL);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // Pins of ports A to C start as inputs with data bits cleared, so no pull-ups at power-up.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      outA <= `GPO_RST_BYTE;
      outB <= `GPO_RST_BYTE;
      outC <= `GPO_RST_BYTE;
      dirA <= `GPO_RST_BYTE;
      dirB <= `GPO_RST_BYTE;
      dirC <= `GPO_RST_BYTE;
      ctrl <= `GPO_RST_BYTE;
    end else begin
      if (wrOutA) outA <= regWrData;
      else if (wrPinA) outA <= outA ^ regWrData;
      if (wrOutB) outB <= regWrData;
      else if (wrPinB) outB <= outB ^ regWrData;
      if (wrOutC) outC <= regWrData;
      else if (wrPinC) outC <= outC ^ regWrData;
      if (wrDirA) dirA <= regWrData;
      if (wrDirB) dirB <= regWrData;
      if (wrDirC) dirC <= regWrData;
      if (wrCtrl) ctrl <= regWrData & `GPO_CTRL_RW_MASK;
    end
  end

  assign globalPullupDisable = ctrl[`GPO_CTRL_PUD];
  assign scanPortDisable = ctrl[`GPO_CTRL_SCAN_DIS];
  assign vectorTableSelect = ctrl[`GPO_CTRL_VEC_SEL];
  assign vectorChangeEnable = ctrl[`GPO_CTRL_VEC_CHG];

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped offsets read as zero; data stands one cycle after the strobe only.
  always_comb begin
    unique case (regAddr)
      `GPO_OFS_PIN_A: next_rdData = levA;
      `GPO_OFS_DIR_A: next_rdData = dirA;
      `GPO_OFS_OUT_A: next_rdData = outA;
      `GPO_OFS_PIN_B: next_rdData = levB;
      `GPO_OFS_DIR_B: next_rdData = dirB;
      `GPO_OFS_OUT_B: next_rdData = outB;
      `GPO_OFS_PIN_C: next_rdData = levC;
      `GPO_OFS_DIR_C: next_rdData = dirC;
      `GPO_OFS_OUT_C: next_rdData = outC;
      `GPO_OFS_CTRL: next_rdData = ctrl;
      default: next_rdData = `GPO_RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= `GPO_RST_BYTE;
    end else if (clkEn) begin
      regRdData <= regRdStrobe ? next_rdData : `GPO_RST_BYTE;
    end
  end

  // ----------------------------------------
  // Ports A to C: no overrides
  // ----------------------------------------
  // Sleep gating still applies to these inputs, which keeps floating pins quiet.
  gpo_pin_cell #(.WIDTH(8)) cellA (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .pinIn(portAPinIn), .dirBit(dirA), .outBit(outA),
    .pullupDisable(globalPullupDisable), .sleepGate(sleepInputDisable),
    .pullup_override_en('0), .pullup_override_val('0), .dir_override_en('0), .dir_override_val('0), .outval_override_en('0), .outval_override_val('0), .input_en_override_en('0), .input_en_override_val('0),
    .pinOut(portAPinOut), .pinOe(portAPinOe), .pullupOn(portAPullup), .inLevel(levA)
  );
  gpo_pin_cell #(.WIDTH(8)) cellB (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .pinIn(portBPinIn), .dirBit(dirB), .outBit(outB),
    .pullupDisable(globalPullupDisable), .sleepGate(sleepInputDisable),
    .pullup_override_en('0), .pullup_override_val('0), .dir_override_en('0), .dir_override_val('0), .outval_override_en('0), .outval_override_val('0), .input_en_override_en('0), .input_en_override_val('0),
    .pinOut(portBPinOut), .pinOe(portBPinOe), .pullupOn(portBPullup), .inLevel(levB)
  );
  gpo_pin_cell #(.WIDTH(8)) cellC (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .pinIn(portCPinIn), .dirBit(dirC), .outBit(outC),
    .pullupDisable(globalPullupDisable), .sleepGate(sleepInputDisable),
    .pullup_override_en('0), .pullup_override_val('0), .dir_override_en('0), .dir_override_val('0), .outval_override_en('0), .outval_override_val('0), .input_en_override_en('0), .input_en_override_val('0),
    .pinOut(portCPinOut), .pinOe(portCPinOe), .pullupOn(portCPullup), .inLevel(levC)
  );

  // ----------------------------------------
  // Port D override signals
  // ----------------------------------------
  // The serial enables own pins 1 and 0; upper pins see no pull-up or direction overrides.
  wire logic [1:0] serialEn = {serialTxEnable, serialRxEnable};
  wire logic [1:0] serialPuov = portDOutputData[1:0] & {2{~globalPullupDisable}};
  wire gpo_byte_t dPuoe = {6'h00, serialEn};
  wire gpo_byte_t dPuov = {6'h00, serialPuov};
  wire gpo_byte_t dDdoe = {6'h00, serialEn};
  wire gpo_byte_t dDdov = {6'h00, 2'h2};
  // The transmit value sits on pin 1, so the low nibble carries it one place up.
  wire gpo_byte_t dPvoe = {compareOutEnable, 2'h0, serialTxEnable, 1'h0};
  wire gpo_byte_t dPvov = {compareOutValue, 2'h0, serialTxData, 1'h0};
  wire gpo_byte_t pcForce = pinchangeMask & {8{pinchangeGroup3Enable}};
  wire gpo_byte_t dDieoe = pcForce | {4'h0, extIrqEnable, 2'h0};

  gpo_pin_cell #(.WIDTH(8)) cellD (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn), .pinIn(portDPinIn), .dirBit(portDDirection),
    .outBit(portDOutputData), .pullupDisable(globalPullupDisable), .sleepGate(sleepInputDisable),
    .pullup_override_en(dPuoe), .pullup_override_val(dPuov), .dir_override_en(dDdoe), .dir_override_val(dDdov), .outval_override_en(dPvoe), .outval_override_val(dPvov),
    .input_en_override_en(dDieoe), .input_en_override_val('1),
    .pinOut(portDPinOut), .pinOe(portDPinOe), .pullupOn(portDPullup), .inLevel(levD)
  );

  // ----------------------------------------
  // Port D peripheral inputs
  // ----------------------------------------
  // Change sources 24 to 31 are the synchronised, gated pin levels in order.
  assign pinchangeIn = levD;
  assign extIrqIn = {levD[`GPO_IRQ1_PIN], levD[`GPO_IRQ0_PIN]};
  assign timer1CaptureIn = levD[`GPO_CAPTURE_PIN];
  assign serialRxPin = levD[`GPO_RX_PIN];
  assign portDSlewCtrl = {2{twowireEnable}};

  // ----------------------------------------
  // Two-wire spike filters
  // ----------------------------------------
  // A level is only accepted after it holds for SPIKE_CYCLES edges; the cost is latency.
  wire logic [1:0] filtOut;
  wire logic [1:0] twiRaw = levD[1:0];

  // Each lane keeps its own flops, so no variable is written by two processes.
  for (genvar g = 0; g < 2; g++) begin : gFilt
    logic filtLast;
    logic filtQ;
    logic [7:0] filtCnt;
    wire logic same = (twiRaw[g] == filtLast);
    wire logic done = (filtCnt >= 8'(SPIKE_CYCLES - 1));
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        filtLast <= 1'h0;
        filtCnt <= 8'h00;
        filtQ <= 1'h0;
      end else if (clkEn) begin
        filtLast <= twiRaw[g];
        filtCnt <= same ? (done ? filtCnt : filtCnt + 8'h01) : 8'h00;
        if (same && done && twowireEnable) filtQ <= twiRaw[g];
      end
    end
    assign filtOut[g] = filtQ;
  end

  assign twowireSdaIn = filtOut[`GPO_TX_PIN];
  assign twowireSclIn = filtOut[`GPO_RX_PIN];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_tx_forced_out: assert property (@(posedge mclk) disable iff (!resetn)
    serialTxEnable |-> portDPinOe[`GPO_TX_PIN] && portDPinOut[`GPO_TX_PIN] == serialTxData)
    else $error("transmit pin not driven while transmitter enabled");

  a_rx_forced_in: assert property (@(posedge mclk) disable iff (!resetn)
    serialRxEnable |-> !portDPinOe[`GPO_RX_PIN])
    else $error("receive pin driven while receiver enabled");

  a_rx_pullup_data: assert property (@(posedge mclk) disable iff (!resetn)
    serialRxEnable |-> portDPullup[`GPO_RX_PIN] == (portDOutputData[0] & ~globalPullupDisable))
    else $error("receive pin pull-up does not follow its data bit");

  a_pud_all_off: assert property (@(posedge mclk) disable iff (!resetn)
    globalPullupDisable |-> (portAPullup | portBPullup | portCPullup | portDPullup) == 8'h00)
    else $error("pull-up on while globally disabled");

  a_cmp_replaces_out: assert property (@(posedge mclk) disable iff (!resetn)
    ((portDPinOut[7:4] & compareOutEnable) == (compareOutValue & compareOutEnable))
    && portDPinOe[7:4] == portDDirection[7:4])
    else $error("compare output not passed to upper pin");

  a_irq_gated: assert property (@(posedge mclk) disable iff (!resetn)
    sleepInputDisable && extIrqEnable == 2'h0 && pcForce[3:2] == 2'h0 |-> extIrqIn == 2'h0)
    else $error("interrupt input not gated in sleep");

  a_capture_pair: assert property (@(posedge mclk) disable iff (!resetn)
    timer1CaptureIn == pinchangeIn[`GPO_CAPTURE_PIN])
    else $error("capture input differs from change source 30");

  a_slew_follows: assert property (@(posedge mclk) disable iff (!resetn)
    portDSlewCtrl == {2{twowireEnable}})
    else $error("slew control does not follow two-wire enable");

  a_data_readback: assert property (@(posedge mclk) disable iff (!resetn)
    clkEn && wrOutA ##1 clkEn && regRdStrobe && regAddr == `GPO_OFS_OUT_A && !wrEn
    |=> regRdData == $past(regWrData, 2))
    else $error("data register read-back mismatch");

  a_ctrl_reserved: assert property (@(posedge mclk) disable iff (!resetn)
    (ctrl & ~`GPO_CTRL_RW_MASK) == 8'h00)
    else $error("reserved control bit set");

  c_tx_over_dir: cover property (@(posedge mclk) disable iff (!resetn)
    serialTxEnable && !portDDirection[`GPO_TX_PIN]);
  c_pud_set: cover property (@(posedge mclk) disable iff (!resetn)
    globalPullupDisable && portAPinOe == 8'h00 && outA != 8'h00);
  c_cmp_active: cover property (@(posedge mclk) disable iff (!resetn) compareOutEnable != 4'h0);
  c_twi_filter: cover property (@(posedge mclk) disable iff (!resetn) twowireEnable && $rose(twowireSdaIn));

endmodule : gpo_port

`default_nettype wire

// ### verification/gpo_periph_model.sv
// Peripheral-side model: serial port, timers, interrupt and pin-change controls.
// Assumes the bench loads one packed control word; outputs change only on the clock.
`default_nettype none
// ------------------------------------------------------------
// Peripheral control model
// ------------------------------------------------------------
module gpo_periph_model (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [38:0] cfgWord,
  output gpo_pkg::gpo_byte_t dDir,
  output gpo_pkg::gpo_byte_t dData,
  output gpo_pkg::gpo_byte_t pcMask,
  output logic [3:0] cmpEn,
  output logic [3:0] cmpVal,
  output logic [1:0] irqEn,
  output logic serial_tx_enable,
  output logic serial_rx_enable,
  output logic txData,
  output logic pcGrp,
  output logic twowire_enable
);
  import gpo_pkg::*;
  logic [38:0] held;
  // Controls come from flops, as real peripherals drive them; no glitches at the port.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      held <= '0;
    end else begin
      held <= cfgWord;
    end
  end
  // Field order of the control word, most significant first.
  assign {dDir, dData, pcMask, cmpEn, cmpVal, irqEn, serial_tx_enable, serial_rx_enable, txData, pcGrp, twowire_enable} = held;
endmodule : gpo_periph_model
`default_nettype wire

// ### verification/gpo_port_tb_top.sv
// Self-checking bench of the port block with the peripheral model on its override side.
// Assumes the design files and the peripheral model are compiled before it.
`default_nettype none
`include "gpo_cfg.svh"
// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module gpo_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gpo_pkg::*;
  localparam int SPIKE = 3;
  logic mclk = 1'h0;
  logic resetn = 1'h0;
  logic clkEn = 1'h1;
  gpo_addr_t regAddr = '0;
  gpo_byte_t regWrData = '0;
  logic regWrStrobe = 1'h0;
  logic regRdStrobe = 1'h0;
  logic sleepIn = 1'h0;
  gpo_byte_t port_a_pin_levels = '0, port_b_pin_levels = '0, pinC = '0, pinD = '0;
  logic [38:0] cfgWord = '0;
  gpo_byte_t rdData, aOut, aOe, aPu, bOut, bOe, bPu, cOut, cOe, cPu, dOut, dOe, dPu, dDir, dData, pcMask, pcIn;
  logic [3:0] cmpEn, cmpVal;
  logic [1:0] irqEn, irqIn, slew;
  logic serial_tx_enable, serial_rx_enable, txData, pcGrp, twowire_enable, rxPin, capIn, scl, sda, scanDis, vecSel, vecChg;
  int fails = 0;
  int nChecks = 0;
  gpo_addr_t ofs [10] = '{`GPO_OFS_PIN_A, `GPO_OFS_DIR_A, `GPO_OFS_OUT_A, `GPO_OFS_PIN_B, `GPO_OFS_DIR_B,
    `GPO_OFS_OUT_B, `GPO_OFS_PIN_C, `GPO_OFS_DIR_C, `GPO_OFS_OUT_C, `GPO_OFS_CTRL};
  // Clock at 50 MHz.
  always #10 mclk = ~mclk;
  gpo_port #(.SPIKE_CYCLES(SPIKE)) u_gpo_port (.mclk(mclk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(rdData),
    .portAPinIn(port_a_pin_levels), .portAPinOut(aOut), .portAPinOe(aOe), .portAPullup(aPu), .portBPinIn(port_b_pin_levels),
    .portBPinOut(bOut), .portBPinOe(bOe), .portBPullup(bPu), .portCPinIn(pinC), .portCPinOut(cOut),
    .portCPinOe(cOe), .portCPullup(cPu), .portDPinIn(pinD), .portDOutputData(dData), .portDDirection(dDir),
    .portDPinOut(dOut), .portDPinOe(dOe), .portDPullup(dPu), .portDSlewCtrl(slew), .sleepInputDisable(sleepIn),
    .serialTxEnable(serial_tx_enable), .serialRxEnable(serial_rx_enable), .serialTxData(txData), .serialRxPin(rxPin),
    .compareOutEnable(cmpEn), .compareOutValue(cmpVal), .timer1CaptureIn(capIn), .extIrqEnable(irqEn),
    .extIrqIn(irqIn), .pinchangeMask(pcMask), .pinchangeGroup3Enable(pcGrp), .pinchangeIn(pcIn),
    .twowireEnable(twowire_enable), .twowireSclIn(scl), .twowireSdaIn(sda), .scanPortDisable(scanDis),
    .vectorTableSelect(vecSel), .vectorChangeEnable(vecChg));
  gpo_periph_model u_gpo_periph_model (.mclk(mclk), .resetn(resetn), .cfgWord(cfgWord), .dDir(dDir),
    .dData(dData), .pcMask(pcMask), .cmpEn(cmpEn), .cmpVal(cmpVal), .irqEn(irqEn), .serial_tx_enable(serial_tx_enable), .serial_rx_enable(serial_rx_enable),
    .txData(txData), .pcGrp(pcGrp), .twowire_enable(twowire_enable));
  // Compare, bus and configuration helpers.
  task automatic chk(input string what, input gpo_byte_t exp, input gpo_byte_t got);
    nChecks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input gpo_addr_t a, input gpo_byte_t d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'h1;
    @(posedge mclk);
    regWrStrobe <= 1'h0;
    #1;
  endtask : wr
  task automatic rdChk(input string what, input gpo_addr_t a, input gpo_byte_t exp);
    @(posedge mclk);
    regAddr <= a;
    regRdStrobe <= 1'h1;
    @(posedge mclk);
    regRdStrobe <= 1'h0;
    #1;
    chk(what, exp, rdData);
  endtask : rdChk
  // Three edges cover the model flop and the two synchroniser stages.
  task automatic setCfg(input logic [38:0] w);
    @(posedge mclk);
    cfgWord <= w;
    repeat (3) @(posedge mclk);
    #1;
  endtask : setCfg
  function automatic gpo_byte_t pullOf(input gpo_byte_t dir, input gpo_byte_t dat, input logic global_pullup_disable);
    return ~dir & dat & {8{~global_pullup_disable}};
  endfunction : pullOf
  // Port D pin expectations worked out from the peripheral controls.
  task automatic checkD(input logic global_pullup_disable);
    gpo_byte_t eOut, eOe, ePu;
    eOut = dData;
    eOe = dDir;
    ePu = pullOf(dDir, dData, global_pullup_disable);
    for (int i = 4; i < 8; i++) eOut[i] = cmpEn[i-4] ? cmpVal[i-4] : dData[i];
    if (serial_tx_enable) begin
      eOut[1] = txData;
      eOe[1] = 1'h1;
      ePu[1] = dData[1] & ~global_pullup_disable;
    end
    if (serial_rx_enable) begin
      eOe[0] = 1'h0;
      ePu[0] = dData[0] & ~global_pullup_disable;
    end
    chk("D out", eOut, dOut);
    chk("D oe", eOe, dOe);
    chk("D pullup", ePu, dPu);
  endtask : checkD
  task automatic wrap_up;
    if (fails == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (50000) @(posedge mclk);
    fails++;
    wrap_up();
  end
  // Main sequence: registers, pins, port D overrides, inputs, two-wire filter.
  initial begin
    gpo_byte_t dirV, datV, frc;
    logic global_pullup_disable;
    logic [38:0] w;
    void'($urandom(23711));
    repeat (10) @(posedge mclk);
    resetn <= 1'h1;
    foreach (ofs[i]) rdChk("reset value", ofs[i], 8'h00);
    wr(`GPO_OFS_CTRL, 8'hff);
    rdChk("ctrl", `GPO_OFS_CTRL, 8'h93);
    @(posedge mclk);
    #1;
    chk("read idle", 8'h00, rdData);
    chk("ctrl outs", 8'h07, {5'h00, scanDis, vecSel, vecChg});
    rdChk("unmapped", 6'h3f, 8'h00);
    repeat (16) begin
      dirV = gpo_byte_t'($urandom());
      datV = gpo_byte_t'($urandom());
      global_pullup_disable = 1'($urandom());
      wr(`GPO_OFS_CTRL, {3'h0, global_pullup_disable, 4'h0});
      wr(`GPO_OFS_DIR_A, dirV);
      wr(`GPO_OFS_OUT_A, datV);
      wr(`GPO_OFS_DIR_B, ~dirV);
      wr(`GPO_OFS_OUT_B, datV);
      wr(`GPO_OFS_DIR_C, datV);
      wr(`GPO_OFS_OUT_C, dirV);
      chk("A out", datV, aOut);
      chk("A oe", dirV, aOe);
      chk("A pullup", pullOf(dirV, datV, global_pullup_disable), aPu);
      chk("B pullup", pullOf(~dirV, datV, global_pullup_disable), bPu);
      chk("C pullup", pullOf(datV, dirV, global_pullup_disable), cPu);
      chk("B out", datV, bOut);
      chk("B oe", ~dirV, bOe);
      chk("C out", dirV, cOut);
      chk("C oe", datV, cOe);
      rdChk("B dir", `GPO_OFS_DIR_B, ~dirV);
      rdChk("C data", `GPO_OFS_OUT_C, dirV);
    end
    @(posedge mclk);
    clkEn <= 1'h0;
    wr(`GPO_OFS_OUT_A, ~datV);
    clkEn <= 1'h1;
    rdChk("frozen write", `GPO_OFS_OUT_A, datV);
    wr(`GPO_OFS_PIN_A, 8'h0f);
    rdChk("toggle", `GPO_OFS_OUT_A, datV ^ 8'h0f);
    port_a_pin_levels <= gpo_byte_t'($urandom());
    port_b_pin_levels <= gpo_byte_t'($urandom());
    pinC <= gpo_byte_t'($urandom());
    repeat (2) @(posedge mclk);
    rdChk("A pins", `GPO_OFS_PIN_A, port_a_pin_levels);
    rdChk("B pins", `GPO_OFS_PIN_B, port_b_pin_levels);
    rdChk("C pins", `GPO_OFS_PIN_C, pinC);
    wr(`GPO_OFS_CTRL, 8'h00);
    setCfg({8'h01, 8'hff, 8'h00, 4'h0, 4'h0, 2'h0, 5'h1c});
    checkD(1'h0);
    repeat (24) begin
      w = 39'({$urandom(), $urandom()});
      w[0] = 1'h0;
      global_pullup_disable = 1'($urandom());
      wr(`GPO_OFS_CTRL, {3'h0, global_pullup_disable, 4'h0});
      setCfg(w);
      checkD(global_pullup_disable);
    end
    sleepIn <= 1'h1;
    repeat (10) begin
      pinD <= gpo_byte_t'($urandom());
      w = 39'({$urandom(), $urandom()});
      w[0] = 1'h0;
      setCfg(w);
      frc = pcMask & {8{pcGrp}};
      frc[2] = frc[2] | irqEn[0];
      frc[3] = frc[3] | irqEn[1];
      chk("pinchange", pinD & frc, pcIn);
      chk("ext irq", {6'h00, pinD[3] & frc[3], pinD[2] & frc[2]}, irqIn);
      chk("capture", pinD[6] & frc[6], capIn);
    end
    sleepIn <= 1'h0;
    setCfg(39'h0);
    chk("pinchange open", pinD, pcIn);
    chk("capture open", pinD[6], capIn);
    chk("rx pin", pinD[0], rxPin);
    pinD <= 8'h02;
    setCfg(39'h1);
    chk("slew on", 8'h03, slew);
    repeat (SPIKE + 4) @(posedge mclk);
    pinD <= 8'h01;
    @(posedge mclk);
    pinD <= 8'h02;
    repeat (SPIKE + 4) begin
      @(posedge mclk);
      #1;
      chk("filtered sda", 8'h01, sda);
      chk("filtered scl", 8'h00, scl);
    end
    setCfg(39'h0);
    chk("slew off", 8'h00, slew);
    wrap_up();
  end
endmodule : gpo_port_tb_top
`default_nettype wire
